// File: hw/adcc_pkg.sv
// Package for the converter control block: register indices, field layout, divider figures.
// Assumes one 32-bit Avalon-MM word per 8-bit register.
package adcc_pkg;
	// ********************************
	// Register map (index; byte address is four times it)
	// ********************************
	localparam int unsigned ADDR_W = 10;
	localparam logic [7:0] IDX_CLKDIV = 8'hF2;
	localparam logic [7:0] IDX_CTRL = 8'hF3;
	localparam logic [7:0] IDX_RES_LO = 8'hF4;
	localparam logic [7:0] IDX_RES_HI = 8'hF5;
	localparam logic [7:0] IDX_PIN_CFG = 8'hF6;
	localparam logic [7:0] IDX_IRQ_STAT = 8'hF7;
	localparam logic [7:0] IDX_IRQ_MASK = 8'hF8;
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [23:0] READ_PAD = 24'h000000;

	// ********************************
	// Field layout
	// ********************************
	localparam int unsigned CTRL_QUIET = 6;
	localparam int unsigned CTRL_ENABLE = 5;
	localparam int unsigned CTRL_DONE = 4;
	localparam int unsigned CTRL_START = 3;
	localparam int unsigned CH_W = 3;
	localparam int unsigned DIV_W = 5;
	localparam int unsigned RES_W = 10;
	localparam int unsigned RES_HI_LSB = 2;
	localparam int unsigned RES_LO_W = 2;
	localparam int unsigned IRQ_DONE = 0;
	localparam int unsigned IRQ_REFUSED = 1;
	localparam int unsigned IRQ_W = 2;

	// ********************************
	// Converter clock and sequence
	// ********************************
	localparam logic [7:0] MULT_NORMAL = 8'h04;
	localparam logic [7:0] MULT_DOUBLE = 8'h02;
	localparam logic [7:0] ZERO_NORMAL = 8'h80;
	localparam logic [7:0] ZERO_DOUBLE = 8'h40;
	localparam logic [3:0] CONV_PERIODS = 4'hB;

	typedef enum logic [1:0] {ADCC_IDLE, ADCC_SAMPLE, ADCC_CONVERT} adcc_phase_e;
endpackage

// File: hw/adcc_top.sv
// Converter control: register slave, clock prescaler, sample and successive-step sequence.
// Assumes an analog core that holds the sampled input and answers one comparator bit
// against the trial code; the core's clock equals sys_clk_in.
`timescale 1ns/100ps
`default_nettype none
module adcc_top (
	input wire logic sys_clk_in,
	input wire logic rst_n_in,
	input wire logic [adcc_pkg::ADDR_W-1:0] avs_address_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic [31:0] avs_writedata_in,
	input wire logic [3:0] avs_byteenable_in,
	output logic [31:0] avs_readdata_out,
	output logic avs_waitrequest_out,
	input wire logic double_speed_core_in,
	input wire logic comparator_in,
	output logic conv_power_out,
	output logic [adcc_pkg::CH_W-1:0] conv_channel_out,
	output logic conv_sample_out,
	output logic conv_clk_out,
	output logic [adcc_pkg::RES_W-1:0] conv_trial_code_out,
	output logic cpu_halt_out,
	output logic irq_out
);
	// ********************************
	// State
	// ********************************
	typedef struct packed {
		logic [adcc_pkg::DIV_W-1:0] divider_value;
		logic quiet_conversion;
		logic converter_enable;
		logic conversion_done_flag;
		logic conversion_start_bit;
		logic [adcc_pkg::CH_W-1:0] channel_select;
		logic [7:0] pin_analog_select;
		logic [adcc_pkg::RES_W-1:0] result;
		logic refused_flag;
		logic [adcc_pkg::IRQ_W-1:0] irq_mask;
		adcc_pkg::adcc_phase_e phase;
		logic [3:0] bit_idx;
		logic [adcc_pkg::RES_W-1:0] trial;
		logic [adcc_pkg::CH_W-1:0] conv_chan;
		logic [7:0] div_cnt;
		logic tick;
		logic sample;
		logic cmp_meta;
		logic cmp_sync;
		logic halt;
		logic irq;
		logic waitrequest;
		logic [7:0] rdata;
	} adcc_state_s;

	localparam adcc_state_s RESET_STATE = '{phase: adcc_pkg::ADCC_IDLE, waitrequest: 1'b1, default: '0};

	adcc_state_s state_reg;
	adcc_state_s state_next;
	logic wr_ctrl_start;
	logic done_ev;
	logic refused_ev;

	// ********************************
	// Decoding
	// ********************************
	function automatic logic [7:0] div_len(input logic [adcc_pkg::DIV_W-1:0] prs, input logic dbl);
		logic [7:0] w;
		w = 8'(prs);
		if (prs == '0) begin
			div_len = dbl ? adcc_pkg::ZERO_DOUBLE : adcc_pkg::ZERO_NORMAL;
		end else begin
			div_len = dbl ? 8'(w * adcc_pkg::MULT_DOUBLE) : 8'(w * adcc_pkg::MULT_NORMAL);
		end
	endfunction

	// Reserved bits read as zero
	function automatic logic [7:0] read_byte(input logic [7:0] idx, input adcc_state_s s);
		logic [7:0] b;
		b = adcc_pkg::REG_RESET;
		unique case (idx)
			adcc_pkg::IDX_CLKDIV: b[adcc_pkg::DIV_W-1:0] = s.divider_value;
			adcc_pkg::IDX_CTRL: begin
				b[adcc_pkg::CTRL_QUIET] = s.quiet_conversion;
				b[adcc_pkg::CTRL_ENABLE] = s.converter_enable;
				b[adcc_pkg::CTRL_DONE] = s.conversion_done_flag;
				b[adcc_pkg::CTRL_START] = s.conversion_start_bit;
				b[adcc_pkg::CH_W-1:0] = s.channel_select;
			end
			adcc_pkg::IDX_RES_LO: b[adcc_pkg::RES_LO_W-1:0] = s.result[adcc_pkg::RES_LO_W-1:0];
			adcc_pkg::IDX_RES_HI: b = s.result[adcc_pkg::RES_W-1:adcc_pkg::RES_HI_LSB];
			adcc_pkg::IDX_PIN_CFG: b = s.pin_analog_select;
			adcc_pkg::IDX_IRQ_STAT: begin
				b[adcc_pkg::IRQ_DONE] = s.conversion_done_flag;
				b[adcc_pkg::IRQ_REFUSED] = s.refused_flag;
			end
			adcc_pkg::IDX_IRQ_MASK: b[adcc_pkg::IRQ_W-1:0] = s.irq_mask;
			default: b = adcc_pkg::REG_RESET;
		endcase
		return b;
	endfunction

	// ********************************
	// Next state
	// ********************************
	always_comb begin
		logic req;
		logic wr;
		logic [7:0] idx;
		logic [7:0] wd;
		state_next = state_reg;
		done_ev = 1'b0;
		refused_ev = 1'b0;
		wr_ctrl_start = 1'b0;
		req = avs_read_in | avs_write_in;
		idx = avs_address_in[adcc_pkg::ADDR_W-1:2];
		wd = avs_writedata_in[7:0];
		wr = avs_write_in && !state_reg.waitrequest && avs_address_in[1:0] == 2'b00 && avs_byteenable_in[0];
		state_next.cmp_meta = comparator_in;
		state_next.cmp_sync = state_reg.cmp_meta;
		state_next.tick = 1'b0;
		// One wait cycle per access keeps read data a flip-flop output
		state_next.waitrequest = !(req && state_reg.waitrequest);
		if (req && state_reg.waitrequest) begin
			state_next.rdata = (avs_address_in[1:0] == 2'b00) ? read_byte(idx, state_reg) : adcc_pkg::REG_RESET;
		end
		if (wr) begin
			unique case (idx)
				adcc_pkg::IDX_CLKDIV: state_next.divider_value = wd[adcc_pkg::DIV_W-1:0];
				adcc_pkg::IDX_CTRL: begin
					state_next.quiet_conversion = wd[adcc_pkg::CTRL_QUIET];
					state_next.converter_enable = wd[adcc_pkg::CTRL_ENABLE];
					state_next.channel_select = wd[adcc_pkg::CH_W-1:0];
					if (!wd[adcc_pkg::CTRL_DONE]) begin
						state_next.conversion_done_flag = 1'b0;
					end
					wr_ctrl_start = wd[adcc_pkg::CTRL_START];
				end
				adcc_pkg::IDX_PIN_CFG: state_next.pin_analog_select = wd;
				adcc_pkg::IDX_IRQ_STAT: begin
					if (wd[adcc_pkg::IRQ_DONE]) begin
						state_next.conversion_done_flag = 1'b0;
					end
					if (wd[adcc_pkg::IRQ_REFUSED]) begin
						state_next.refused_flag = 1'b0;
					end
				end
				adcc_pkg::IDX_IRQ_MASK: state_next.irq_mask = wd[adcc_pkg::IRQ_W-1:0];
				default: state_next.rdata = state_reg.rdata;
			endcase
		end
		// Starts only from idle, so a busy converter is never restarted
		if (wr_ctrl_start && state_reg.phase == adcc_pkg::ADCC_IDLE && state_reg.converter_enable) begin
			if (state_reg.pin_analog_select[state_next.channel_select]) begin
				state_next.conversion_start_bit = 1'b1;
				state_next.phase = adcc_pkg::ADCC_SAMPLE;
				state_next.conv_chan = state_next.channel_select;
				state_next.div_cnt = '0;
				state_next.halt = state_next.quiet_conversion;
			end else begin
				refused_ev = 1'b1;
			end
		end else if (state_reg.phase != adcc_pkg::ADCC_IDLE) begin
			if (state_reg.div_cnt == 8'(div_len(state_reg.divider_value, double_speed_core_in) - 8'h01)) begin
				state_next.div_cnt = '0;
				state_next.tick = 1'b1;
				unique case (state_reg.phase)
					adcc_pkg::ADCC_SAMPLE: begin
						state_next.phase = adcc_pkg::ADCC_CONVERT;
						state_next.bit_idx = 4'(adcc_pkg::RES_W - 1);
						state_next.trial = '0;
						state_next.trial[adcc_pkg::RES_W-1] = 1'b1;
					end
					default: begin
						// Comparator low drops the trial bit; saturates at either reference
						if (!state_reg.cmp_sync) begin
							state_next.trial[state_reg.bit_idx] = 1'b0;
						end
						if (state_reg.bit_idx == '0) begin
							state_next.result = state_next.trial;
							state_next.phase = adcc_pkg::ADCC_IDLE;
							state_next.conversion_start_bit = 1'b0;
							done_ev = 1'b1;
						end else begin
							state_next.bit_idx = state_reg.bit_idx - 4'h1;
							state_next.trial[state_reg.bit_idx - 4'h1] = 1'b1;
						end
					end
				endcase
			end else begin
				state_next.div_cnt = state_reg.div_cnt + 8'h01;
			end
		end
		// Standby aborts a running conversion
		if (!state_next.converter_enable) begin
			state_next.phase = adcc_pkg::ADCC_IDLE;
			state_next.conversion_start_bit = 1'b0;
			state_next.halt = 1'b0;
		end
		// Set wins over a same-cycle clear
		if (done_ev) begin
			state_next.conversion_done_flag = 1'b1;
			if (state_reg.irq_mask[adcc_pkg::IRQ_DONE]) begin
				state_next.halt = 1'b0;
			end
		end
		if (refused_ev) begin
			state_next.refused_flag = 1'b1;
		end
		state_next.sample = state_next.phase == adcc_pkg::ADCC_SAMPLE;
		state_next.irq = |({state_next.refused_flag, state_next.conversion_done_flag} & state_next.irq_mask);
	end

	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state_reg <= RESET_STATE;
		end else begin
			state_reg <= state_next;
		end
	end

	assign avs_readdata_out = {adcc_pkg::READ_PAD, state_reg.rdata};
	assign avs_waitrequest_out = state_reg.waitrequest;
	assign conv_power_out = state_reg.converter_enable;
	assign conv_channel_out = state_reg.conv_chan;
	assign conv_sample_out = state_reg.sample;
	assign conv_clk_out = state_reg.tick;
	assign conv_trial_code_out = state_reg.trial;
	assign cpu_halt_out = state_reg.halt;
	assign irq_out = state_reg.irq;

	// ********************************
	// Checks
	// ********************************
	logic [7:0] gap_cnt;
	logic [3:0] per_cnt;
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			gap_cnt <= '0;
			per_cnt <= '0;
		end else begin
			gap_cnt <= state_reg.tick ? 8'h00 : gap_cnt + 8'h01;
			per_cnt <= (state_reg.phase == adcc_pkg::ADCC_IDLE) ? 4'h0 : per_cnt + 4'(state_reg.tick);
		end
	end

	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (!rst_n_in);

	a_start_done_clear: assert property ($rose(state_reg.conversion_done_flag) |->
		!state_reg.conversion_start_bit && state_reg.phase == adcc_pkg::ADCC_IDLE)
		else $error("start bit still set at end of conversion");
	a_irq_follows_flag: assert property (state_reg.conversion_done_flag && state_reg.irq_mask[adcc_pkg::IRQ_DONE]
		|-> irq_out)
		else $error("done flag enabled but no interrupt");
	a_no_restart: assert property (state_reg.phase == adcc_pkg::ADCC_CONVERT |=>
		state_reg.phase != adcc_pkg::ADCC_SAMPLE)
		else $error("conversion restarted while busy");
	a_channel_held: assert property (state_reg.phase != adcc_pkg::ADCC_IDLE && $past(state_reg.phase) !=
		adcc_pkg::ADCC_IDLE |-> $stable(conv_channel_out))
		else $error("channel changed during conversion");
	a_refused_start: assert property (refused_ev |=> state_reg.phase == adcc_pkg::ADCC_IDLE &&
		state_reg.refused_flag && !state_reg.conversion_start_bit)
		else $error("start on digital pin had an effect");
	a_eleven_periods: assert property (done_ev |-> per_cnt == 4'(adcc_pkg::CONV_PERIODS - 4'h1))
		else $error("conversion length is not eleven periods");
	a_clock_div: assert property (state_reg.tick && state_reg.phase == adcc_pkg::ADCC_CONVERT &&
		$past(state_reg.phase) == adcc_pkg::ADCC_CONVERT && $stable(state_reg.divider_value)
		|-> gap_cnt == 8'(div_len(state_reg.divider_value, double_speed_core_in) - 8'h01))
		else $error("converter clock period wrong");
	a_standby_idle: assert property (!conv_power_out |-> state_reg.phase == adcc_pkg::ADCC_IDLE)
		else $error("conversion running in standby");
	a_quiet_halt: assert property ($rose(state_reg.conversion_start_bit) && state_reg.quiet_conversion
		|-> cpu_halt_out)
		else $error("quiet conversion did not halt");
	a_wait_single: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
		else $error("waitrequest low for more than one cycle");

	c_conversion_done: cover property ($rose(state_reg.conversion_done_flag));
	c_refused: cover property (refused_ev);
	c_halt_release: cover property ($fell(cpu_halt_out) && irq_out);
endmodule
`default_nettype wire

// File: verif/adcc_core_model.sv
// Behavioural analog core: holds the selected input at sample time, compares it with the trial code.
// Assumes levels_in packs eight 11-bit input levels; codes above 3FF stand for input above the reference.
`timescale 1ns/100ps
`default_nettype none
module adcc_core_model (
	input wire logic clk_in,
	input wire logic power_in,
	input wire logic [2:0] channel_in,
	input wire logic sample_in,
	input wire logic [9:0] trial_code_in,
	input wire logic [87:0] levels_in,
	output logic comparator_out
);
	logic [10:0] held;
	logic flip = 1'b0;
	always @(posedge clk_in) begin
		flip <= ~flip;
		if (sample_in) begin
			held <= levels_in[channel_in*11 +: 11];
		end
	end
	// Unpowered core gives a changing level, so a standby conversion cannot look right by luck
	assign comparator_out = power_in ? ({1'b0, trial_code_in} <= held) : flip;
endmodule
`default_nettype wire

// File: verif/tb_top.sv
// Bench for the converter control block: Avalon-MM register tasks, conversion sequences.
// Assumes the core model on the analog side and one 200 MHz clock.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	logic clk = 1'b0, rst_n = 1'b0, rd_r = 1'b0, wr_r = 1'b0, x2 = 1'b0, cmp, pwr, smp, cclk, halt, irq, wq;
	logic [9:0] addr = 10'h000, trial;
	logic [31:0] wd = 32'h00000000, rdd;
	logic [2:0] chn;
	logic [87:0] levels;
	int mismatches = 0, n_tests = 0, cyc = 0, npulse = 0, gap = 0, cnt = 0, p0, t;
	logic [31:0] d, h;
	initial begin
		forever #2.5 clk = ~clk;
	end
	adcc_top adcc_top_i (.sys_clk_in(clk), .rst_n_in(rst_n), .avs_address_in(addr), .avs_read_in(rd_r),
		.avs_write_in(wr_r), .avs_writedata_in(wd), .avs_byteenable_in(4'hF), .avs_readdata_out(rdd),
		.avs_waitrequest_out(wq), .double_speed_core_in(x2), .comparator_in(cmp), .conv_power_out(pwr),
		.conv_channel_out(chn), .conv_sample_out(smp), .conv_clk_out(cclk), .conv_trial_code_out(trial),
		.cpu_halt_out(halt), .irq_out(irq));
	adcc_core_model adcc_core_model_i (.clk_in(clk), .power_in(pwr), .channel_in(chn), .sample_in(smp),
		.trial_code_in(trial), .levels_in(levels), .comparator_out(cmp));
	// ********************************
	// Monitors and timeout
	// ********************************
	always @(posedge clk) begin
		cyc <= cyc + 1;
		cnt <= cclk ? 0 : cnt + 1;
		if (cclk === 1'b1) begin
			npulse <= npulse + 1;
			gap <= cnt + 1;
		end
		if (cyc == 60000) begin
			mismatches = mismatches + 1;
			test_done();
		end
	end
	task automatic test_done();
		$display("compares %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	// ********************************
	// Avalon-MM master
	// ********************************
	// Request held until the rising edge that samples waitrequest low; data taken at that edge
	// One idle edge follows so outputs updated by the access are settled when checked
	task automatic acc(input logic w, input logic [7:0] idx, input logic [7:0] v, output logic [31:0] q);
		@(posedge clk);
		addr <= {idx, 2'b00};
		wd <= {24'h000000, v};
		if (w) begin
			wr_r <= 1'b1;
		end else begin
			rd_r <= 1'b1;
		end
		do begin
			@(posedge clk);
		end while (wq !== 1'b0);
		q = rdd;
		wr_r <= 1'b0;
		rd_r <= 1'b0;
		@(posedge clk);
	endtask
	task automatic wr(input logic [7:0] idx, input logic [7:0] v);
		acc(1'b1, idx, v, h);
	endtask
	task automatic rd(input logic [7:0] idx);
		acc(1'b0, idx, 8'h00, d);
	endtask
	// Start, repeat the start while busy, then poll the start bit
	task automatic conv(input logic [7:0] c);
		p0 = npulse;
		wr(8'hF3, c);
		chk(halt, c[6]);
		wr(8'hF3, c);
		d = 32'h8;
		for (int i = 0; i < 1000 && d[3] !== 1'b0; i++) rd(8'hF3);
	endtask
	task automatic tend();
		$display("test %0d finished", t++);
	endtask
	// ********************************
	// Tests
	// ********************************
	initial begin
		t = 1;
		for (int n = 0; n < 8; n++) levels[n*11 +: 11] = 11'(n * 145);
		levels[87:77] = 11'h7FF;
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		for (int i = 8'hF0; i <= 8'hF8; i++) begin
			rd(8'(i));
			chk(d, 32'h00000000);
		end
		tend();
		wr(8'hF6, 8'hFF);
		wr(8'hF3, 8'h20);
		chk(pwr, 1'b1);
		repeat (800) @(posedge clk);
		wr(8'hF8, 8'h01);
		wr(8'hF2, 8'h01);
		for (int n = 0; n < 8; n++) begin
			conv(8'h28 | 8'(n));
			chk(npulse - p0, 11);
			chk(d[4], 1'b1);
			chk(irq, 1'b1);
			rd(8'hF5);
			h = d;
			rd(8'hF4);
			chk({22'h000000, h[7:0], d[1:0]}, (n == 7) ? 32'h3FF : 32'(n * 145));
			wr(8'hF3, 8'h20);
			chk(irq, 1'b0);
		end
		tend();
		for (int k = 0; k < 4; k++) begin
			x2 <= k[1];
			wr(8'hF2, k[0] ? 8'h03 : 8'h00);
			conv(8'h2D);
			chk(gap, k[1] ? (k[0] ? 6 : 64) : (k[0] ? 12 : 128));
			wr(8'hF3, 8'h20);
		end
		x2 <= 1'b0;
		wr(8'hF2, 8'h01);
		tend();
		wr(8'hF6, 8'hFE);
		conv(8'h28);
		chk(npulse - p0, 0);
		rd(8'hF7);
		chk(d, 32'h2);
		wr(8'hF7, 8'h02);
		wr(8'hF6, 8'hFF);
		tend();
		conv(8'h69);
		chk(halt, 1'b0);
		wr(8'hF3, 8'h20);
		wr(8'hF8, 8'h00);
		conv(8'h2A);
		chk(irq, 1'b0);
		wr(8'hF8, 8'h01);
		chk(irq, 1'b1);
		wr(8'hF7, 8'h01);
		chk(irq, 1'b0);
		tend();
		wr(8'hF3, 8'h00);
		chk(pwr, 1'b0);
		conv(8'h08);
		chk(npulse - p0, 0);
		tend();
		test_done();
	end
endmodule
`default_nettype wire
